/* File: design/vectored_interrupt_control.sv */
`timescale 1ns/1ps
module vic_vectored_interrupt_control #(
  parameter int NUM_SRC = vic_pkg::NUM_SRC
) (
  input  wire logic                              mclk,
  input  wire logic                              arst_n,
  // Peripheral request pulses, same clock domain
  input  wire logic                              secondGroupTimerFive,
  input  wire logic                              secondGroupTimerFour,
  input  wire logic                              secondGroupTimerThree,
  input  wire logic                              auxSerialCh4,
  input  wire logic                              auxSerialCh3,
  input  wire logic                              busCollision,
  input  wire logic                              transferChannelZero,
  input  wire logic                              transferChannelOne,
  input  wire logic                              keyInput,
  input  wire logic                              converterDone,
  input  wire logic                              asyncSerialThirdTx,
  input  wire logic                              asyncSerialThirdRx,
  input  wire logic                              asyncSerialThirdNack,
  input  wire logic                              asyncSerialThirdAck,
  input  wire logic                              asyncSerialThirdI2c,
  input  wire logic                              asyncSerialFirstTx,
  input  wire logic                              asyncSerialFirstRx,
  input  wire logic                              asyncSerialSecondTx,
  input  wire logic                              asyncSerialSecondRx,
  input  wire logic [4:0]                        firstGroupTimer,
  input  wire logic [2:0]                        secondGroupTimer,
  // External pin requests, asynchronous
  input  wire logic                              extIrqPinZero,
  input  wire logic                              extIrqPinOne,
  input  wire logic                              extIrqPinTwo,
  // Request-cause select bits 6 and 7
  input  wire logic                              causeSelSharedA,
  input  wire logic                              causeSelSharedB,
  // Control register write port
  input  wire logic                              ctrlWrite,
  input  wire logic [vic_pkg::NUM_W-1:0]         ctrlIndex,
  input  wire vic_pkg::vic_ctrl_s                ctrlWdata,
  output      vic_pkg::vic_ctrl_s [NUM_SRC-1:0]  ctrlState,
  // Processor flag word fields
  input  wire logic                              flagWrite,
  input  wire vic_pkg::vic_flag_s                flagWdata,
  output      vic_pkg::vic_flag_s                processorFlagWord,
  // Vector base pointer
  input  wire logic                              baseWrite,
  input  wire logic [vic_pkg::ADDR_W-1:0]        baseWdata,
  output      logic [vic_pkg::ADDR_W-1:0]        vectorBasePointer,
  // Break trap and INT instruction vector lookup
  input  wire logic                              swLookup,
  input  wire logic [vic_pkg::NUM_W-1:0]         swNumber,
  // Acceptance handshake with the CPU
  output      logic                              irqPending,
  output      vic_pkg::vic_accept_s              acceptInfo,
  input  wire logic                              cpuAccept
);

  logic [2:0] extPins;
  logic [2:0] pinEdge;
  logic       swLookupHold;
  logic [NUM_SRC-1:0] rawReq;
  logic [NUM_SRC-1:0] setReq;
  logic [NUM_SRC-1:0] eligible;
  logic [vic_pkg::NUM_W-1:0]  bestNum;
  logic [vic_pkg::PRIO_W-1:0] bestLvl;
  logic                       bestValid;
  vic_pkg::vic_ctrl_s [NUM_SRC-1:0] ctrlReg;
  vic_pkg::vic_flag_s flagReg;
  logic [vic_pkg::ADDR_W-1:0] baseReg;
  vic_pkg::vic_accept_s acceptReg;

  // Fixed slots of the peripheral sources
  localparam int MAP_TMRB_FIVE  = 5;
  localparam int MAP_TMRB_FOUR  = 6;
  localparam int MAP_TMRB_THREE = 7;
  localparam int MAP_COLLISION  = 10;
  localparam int MAP_XFER_ZERO  = 11;
  localparam int MAP_XFER_ONE   = 12;
  localparam int MAP_KEY        = 13;
  localparam int MAP_CONVERTER  = 14;
  localparam int MAP_S1_TX      = 17;
  localparam int MAP_S1_RX      = 18;
  localparam int MAP_S2_TX      = 19;
  localparam int MAP_S2_RX      = 20;
  localparam int MAP_TMRA_LO    = 21;
  localparam int MAP_TMRA_HI    = 25;
  localparam int MAP_TMRB_LO    = 26;
  localparam int MAP_TMRB_HI    = 28;
  localparam int MAP_PIN_LO     = 29;
  localparam int MAP_PIN_HI     = 31;

  assign extPins = {extIrqPinTwo, extIrqPinOne, extIrqPinZero};

  // Two-stage pin synchroniser, edge taken behind the second flop
  genvar gs;
  generate
    for (gs = 0; gs < 3; gs++) begin : gPin
      logic pinMeta;
      logic pinSync;
      logic pinLast;
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          pinMeta <= 1'b0;
          pinSync <= 1'b0;
          pinLast <= 1'b0;
        end else begin
          pinMeta <= extPins[gs];
          pinSync <= pinMeta;
          pinLast <= pinSync;
        end
      end
      // Reset low matches idle pin, no false edge
      assign pinEdge[gs] = pinSync & ~pinLast;
    end
  endgenerate

  // Source to number map
  always_comb begin
    rawReq = '0;
    rawReq[vic_pkg::NUM_EXT_THREE] = 1'b0;
    rawReq[MAP_TMRB_FIVE]  = secondGroupTimerFive;
    rawReq[MAP_TMRB_FOUR]  = secondGroupTimerFour;
    rawReq[MAP_TMRB_THREE] = secondGroupTimerThree;
    rawReq[vic_pkg::NUM_SHARED_A] = causeSelSharedA ? 1'b0 : auxSerialCh4;
    rawReq[vic_pkg::NUM_SHARED_B] = causeSelSharedB ? 1'b0 : auxSerialCh3;
    rawReq[MAP_COLLISION] = busCollision;
    rawReq[MAP_XFER_ZERO] = transferChannelZero;
    rawReq[MAP_XFER_ONE]  = transferChannelOne;
    rawReq[MAP_KEY]       = keyInput;
    rawReq[MAP_CONVERTER] = converterDone;
    rawReq[vic_pkg::NUM_I2C_TX] = asyncSerialThirdI2c ? asyncSerialThirdNack
                                                      : asyncSerialThirdTx;
    rawReq[vic_pkg::NUM_I2C_RX] = asyncSerialThirdI2c ? asyncSerialThirdAck
                                                      : asyncSerialThirdRx;
    rawReq[MAP_S1_TX] = asyncSerialFirstTx;
    rawReq[MAP_S1_RX] = asyncSerialFirstRx;
    rawReq[MAP_S2_TX] = asyncSerialSecondTx;
    rawReq[MAP_S2_RX] = asyncSerialSecondRx;
    rawReq[MAP_TMRA_HI:MAP_TMRA_LO] = firstGroupTimer;
    rawReq[MAP_TMRB_HI:MAP_TMRB_LO] = secondGroupTimer;
    rawReq[MAP_PIN_HI:MAP_PIN_LO] = pinEdge;
  end

  assign setReq = rawReq;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : gSrc
      logic accHit;
      logic swWr;
      // Instruction lookups leave pending requests alone
      assign accHit = cpuAccept && acceptReg.valid && !swLookupHold &&
                      (acceptReg.num == vic_pkg::NUM_W'(gi));
      assign swWr   = ctrlWrite && (ctrlIndex == vic_pkg::NUM_W'(gi));

      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          ctrlReg[gi] <= '0;
        end else begin
          if (swWr) begin
            ctrlReg[gi].prio <= ctrlWdata.prio;
          end
          if (setReq[gi]) begin
            ctrlReg[gi].request <= 1'b1;
          end else if (accHit) begin
            ctrlReg[gi].request <= 1'b0;
          end else if (swWr && !ctrlWdata.request) begin
            ctrlReg[gi].request <= 1'b0;
          end
        end
      end

      assign eligible[gi] = ctrlReg[gi].request &&
                            (ctrlReg[gi].prio != vic_pkg::PRIO_OFF) &&
                            (ctrlReg[gi].prio > flagReg.thresh);
    end
  endgenerate

  // Highest level wins, lowest number on ties
  logic [NUM_SRC:0]                      chainValid;
  logic [NUM_SRC:0][vic_pkg::NUM_W-1:0]  chainNum;
  logic [NUM_SRC:0][vic_pkg::PRIO_W-1:0] chainLvl;

  assign chainValid[NUM_SRC] = 1'b0;
  assign chainNum[NUM_SRC]   = '0;
  assign chainLvl[NUM_SRC]   = '0;

  genvar gp;
  generate
    for (gp = 0; gp < NUM_SRC; gp++) begin : gPick
      logic takeThis;
      // Stage gp sees higher numbers first, so ties fall low
      assign takeThis = eligible[gp] && (gp >= vic_pkg::SRC_LO) && (gp <= vic_pkg::SRC_HI) &&
                        (!chainValid[gp+1] || ctrlReg[gp].prio >= chainLvl[gp+1]);
      assign chainValid[gp] = chainValid[gp+1] || takeThis;
      assign chainNum[gp]   = takeThis ? vic_pkg::NUM_W'(gp) : chainNum[gp+1];
      assign chainLvl[gp]   = takeThis ? ctrlReg[gp].prio : chainLvl[gp+1];
    end
  endgenerate

  assign bestValid = chainValid[0];
  assign bestNum   = chainNum[0];
  assign bestLvl   = chainLvl[0];

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      flagReg.gie    <= vic_pkg::RST_GIE;
      flagReg.thresh <= vic_pkg::RST_THRESH;
    end else if (flagWrite) begin
      flagReg <= flagWdata;
    end else if (cpuAccept && acceptReg.valid && !swLookupHold) begin
      flagReg.gie    <= 1'b0;
      flagReg.thresh <= acceptReg.level;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      baseReg <= vic_pkg::RST_VEC_BASE;
    end else if (baseWrite) begin
      baseReg <= baseWdata;
    end
  end

  logic [vic_pkg::NUM_W-1:0] selNum;
  logic [vic_pkg::PRIO_W-1:0] selLvl;
  logic selValid;

  always_comb begin
    selValid = 1'b0;
    selNum   = '0;
    selLvl   = '0;
    if (swLookup) begin
      selValid = 1'b1;
      selNum   = swNumber;
      selLvl   = flagReg.thresh;
    end else if (flagReg.gie && bestValid) begin
      selValid = 1'b1;
      selNum   = bestNum;
      selLvl   = bestLvl;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      acceptReg <= '0;
    end else if (!acceptReg.valid || cpuAccept) begin
      acceptReg.valid <= selValid && !(cpuAccept && acceptReg.valid);
      acceptReg.num   <= selNum;
      acceptReg.level <= selLvl;
      // entry at base plus 4n, full-width add, carries past the area
      acceptReg.vecAddr <= baseReg +
        vic_pkg::ADDR_W'({selNum, vic_pkg::VEC_SHIFT'(0)});
    end
  end

  // Marks an instruction lookup, loaded with the offer
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      swLookupHold <= 1'b0;
    end else if (!acceptReg.valid || cpuAccept) begin
      swLookupHold <= swLookup;
    end
  end

  assign irqPending        = acceptReg.valid;
  assign acceptInfo        = acceptReg;
  assign ctrlState         = ctrlReg;
  assign processorFlagWord = flagReg;
  assign vectorBasePointer = baseReg;

endmodule

/* File: design/vic_pkg.sv */
package vic_pkg;

  localparam int NUM_VEC       = 64;
  localparam int NUM_SRC       = 32;
  localparam int VEC_BYTES     = 4;
  localparam int AREA_BYTES    = 256;
  localparam int ADDR_W        = 20;
  localparam int PRIO_W        = 3;
  localparam int NUM_W         = 6;
  localparam int VEC_SHIFT     = 2;
  localparam int SRC_LO        = 4;
  localparam int SRC_HI        = 31;
  localparam int NUM_BREAK     = 0;
  localparam int NUM_SOFT_LO   = 32;
  localparam int NUM_SHARED_A  = 8;
  localparam int NUM_SHARED_B  = 9;
  localparam int NUM_I2C_TX    = 15;
  localparam int NUM_I2C_RX    = 16;
  localparam int NUM_EXT_THREE = 4;
  localparam int CAUSE_BIT_A   = 6;
  localparam int CAUSE_BIT_B   = 7;
  localparam int CAUSE_REG_ADR = 'h35F;

  localparam logic [ADDR_W-1:0] RST_VEC_BASE = 20'h00000;
  localparam logic [PRIO_W-1:0] RST_THRESH   = 3'h0;
  localparam logic              RST_GIE      = 1'b0;
  localparam logic [PRIO_W-1:0] PRIO_OFF     = 3'h0;

  // One per-source control register
  typedef struct packed {
    logic              request;
    logic [PRIO_W-1:0] prio;
  } vic_ctrl_s;

  // Processor flag word fields held here
  typedef struct packed {
    logic              gie;
    logic [PRIO_W-1:0] thresh;
  } vic_flag_s;

  // Accepted request towards the CPU
  typedef struct packed {
    logic              valid;
    logic [NUM_W-1:0]  num;
    logic [PRIO_W-1:0] level;
    logic [ADDR_W-1:0] vecAddr;
  } vic_accept_s;

endpackage

/* File: dv/vic_vectored_interrupt_control_sva.sv */
`timescale 1ns/1ps
module vic_vectored_interrupt_control_sva #(
  parameter int NUM_SRC = vic_pkg::NUM_SRC
) (
  input wire logic                             mclk,
  input wire logic                             arst_n,
  input wire logic                             ctrlWrite,
  input wire logic [vic_pkg::NUM_W-1:0]        ctrlIndex,
  input wire vic_pkg::vic_ctrl_s               ctrlWdata,
  input wire vic_pkg::vic_ctrl_s [NUM_SRC-1:0] ctrlState,
  input wire vic_pkg::vic_flag_s               processorFlagWord,
  input wire logic [vic_pkg::ADDR_W-1:0]       vectorBasePointer,
  input wire logic                             swLookup,
  input wire logic                             irqPending,
  input wire vic_pkg::vic_accept_s             acceptInfo,
  input wire logic                             cpuAccept
);
  logic maskTake;
  assign maskTake = irqPending && cpuAccept && !acceptInfo.num[5] && acceptInfo.num != 0;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  a_gie_reset: assert property (!$past(arst_n) |-> !processorFlagWord.gie)
    else $error("enable not clear after reset");
  a_mask_gate: assert property (
    $rose(irqPending) && !$past(swLookup) && !acceptInfo.num[5] && acceptInfo.num != 0
    |-> $past(processorFlagWord.gie) && acceptInfo.level > $past(processorFlagWord.thresh))
    else $error("masked request taken");
  a_vec_addr: assert property ($rose(irqPending) && $stable(vectorBasePointer)
    |-> acceptInfo.vecAddr == vectorBasePointer + {acceptInfo.num, 2'b00})
    else $error("vector address wrong");
  a_hold_pending: assert property (
    irqPending && !cpuAccept |=> irqPending && $stable(acceptInfo))
    else $error("pending dropped before accept");
  a_accept_drop: assert property (irqPending && cpuAccept |=> !irqPending)
    else $error("pending not dropped on accept");
  a_accept_clear: assert property (
    maskTake |=> !ctrlState[$past(acceptInfo.num[4:0])].request)
    else $error("request bit not cleared");
  a_flag_update: assert property (maskTake |=> !processorFlagWord.gie
    && processorFlagWord.thresh == $past(acceptInfo.level)) else $error("flags not updated");
  a_sw_one_ignored: assert property (ctrlWrite && ctrlWdata.request
    && !ctrlState[ctrlIndex[4:0]].request |=> !ctrlState[$past(ctrlIndex[4:0])].request)
    else $error("software set a request");
endmodule
bind vic_vectored_interrupt_control vic_vectored_interrupt_control_sva #(.NUM_SRC(NUM_SRC))
  vic_vectored_interrupt_control_sva_inst (.mclk, .arst_n, .ctrlWrite, .ctrlIndex, .ctrlWdata,
  .ctrlState, .processorFlagWord, .vectorBasePointer, .swLookup, .irqPending, .acceptInfo,
  .cpuAccept);

/* File: dv/vic_cpu_model.sv */
`timescale 1ns/1ps
module vic_cpu_model (
  input  wire logic                 mclk,
  input  wire logic                 arst_n,
  input  wire logic                 irqPending,
  input  wire vic_pkg::vic_accept_s acceptInfo,
  input  wire logic [3:0]           waitCycles,
  output logic                      cpuAccept,
  output vic_pkg::vic_accept_s      taken,
  output logic [7:0]                takenCount
);
  logic [3:0] waited;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cpuAccept <= 1'b0;
      waited <= 4'h0;
      taken <= '0;
      takenCount <= 8'h00;
    end else if (cpuAccept) begin
      cpuAccept <= 1'b0;
    end else if (irqPending && waited == waitCycles) begin
      cpuAccept <= 1'b1;
      taken <= acceptInfo;
      takenCount <= takenCount + 8'h01;
      waited <= 4'h0;
    end else if (irqPending) begin
      waited <= waited + 4'h1;
    end
  end
endmodule

/* File: dv/test_vectored_interrupt_control.sv */
`timescale 1ns/1ps
module test_vectored_interrupt_control;
  logic mclk = 0, arst_n = 0, i2c = 0, ctrlWrite = 0, flagWrite = 0, baseWrite = 0, swLookup = 0;
  logic [28:0] pulse = '0;
  logic [1:0] cause = '0;
  logic [5:0] ctrlIndex = '0, swNumber = '0;
  logic [3:0] lat = '0;
  logic [7:0] expCount = '0;
  logic [19:0] baseWdata = '0;
  vic_pkg::vic_ctrl_s ctrlWdata = '0;
  vic_pkg::vic_flag_s flagWdata = '0;
  vic_pkg::vic_ctrl_s [31:0] ctrlState;
  vic_pkg::vic_flag_s processorFlagWord;
  vic_pkg::vic_accept_s acceptInfo, taken;
  logic [19:0] vectorBasePointer;
  logic irqPending, cpuAccept;
  logic [7:0] takenCount;
  int n_errors = 0, checked = 0;
  always #4 mclk = ~mclk;
  vic_vectored_interrupt_control vic_vectored_interrupt_control_inst (.mclk, .arst_n,
    .secondGroupTimerFive(pulse[0]), .secondGroupTimerFour(pulse[1]),
    .secondGroupTimerThree(pulse[2]), .auxSerialCh4(pulse[3]), .auxSerialCh3(pulse[4]),
    .busCollision(pulse[5]), .transferChannelZero(pulse[6]), .transferChannelOne(pulse[7]),
    .keyInput(pulse[8]), .converterDone(pulse[9]), .asyncSerialThirdTx(pulse[10]),
    .asyncSerialThirdRx(pulse[11]), .asyncSerialFirstTx(pulse[12]),
    .asyncSerialFirstRx(pulse[13]), .asyncSerialSecondTx(pulse[14]),
    .asyncSerialSecondRx(pulse[15]), .firstGroupTimer(pulse[20:16]),
    .secondGroupTimer(pulse[23:21]), .asyncSerialThirdNack(pulse[24]),
    .asyncSerialThirdAck(pulse[25]), .asyncSerialThirdI2c(i2c), .extIrqPinZero(pulse[26]),
    .extIrqPinOne(pulse[27]), .extIrqPinTwo(pulse[28]), .causeSelSharedA(cause[0]),
    .causeSelSharedB(cause[1]), .ctrlWrite, .ctrlIndex, .ctrlWdata, .ctrlState, .flagWrite,
    .flagWdata, .processorFlagWord, .baseWrite, .baseWdata, .vectorBasePointer, .swLookup,
    .swNumber, .irqPending, .acceptInfo, .cpuAccept);
  vic_cpu_model vic_cpu_model_inst (.mclk, .arst_n, .irqPending, .acceptInfo,
    .waitCycles(lat), .cpuAccept, .taken, .takenCount);
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wrCtrl(input logic [5:0] n, input logic r, input logic [2:0] p);
    ctrlIndex = n;
    ctrlWdata = '{r, p};
    ctrlWrite = 1;
    tick(1);
    ctrlWrite = 0;
    tick(1);
  endtask
  task automatic wrFlag(input logic g, input logic [2:0] t);
    flagWdata = '{g, t};
    flagWrite = 1;
    tick(1);
    flagWrite = 0;
    tick(1);
  endtask
  task automatic fire(input int i);
    pulse[i] = 1;
    tick(1);
    pulse[i] = 0;
  endtask
  task automatic swCall(input logic [5:0] n);
    swNumber = n;
    swLookup = 1;
    tick(1);
    swLookup = 0;
  endtask
  task automatic take(input logic [5:0] n);
    expCount++;
    for (int k = 0; k < 30 && takenCount !== expCount; k++) tick(1);
    if (takenCount !== expCount) begin
      n_errors++;
      complete_run();
    end
    check("taken number", n, taken.num);
    check("vector address", baseWdata + {n, 2'b00}, taken.vecAddr);
    tick(2);
  endtask
  task automatic none(input string what);
    tick(8);
    check(what, expCount, takenCount);
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    #1 arst_n = 1;
    check("enable at reset", 0, processorFlagWord.gie);
    baseWdata = 20'hABC40;
    baseWrite = 1;
    tick(1);
    baseWrite = 0;
    for (int n = 1; n < 32; n++) wrCtrl(6'(n), 0, 3);
    fire(16);
    none("masked by enable");
    check("request set", 1, ctrlState[21].request);
    wrFlag(1, 0);
    take(21);
    check("request cleared", 0, ctrlState[21].request);
    $display("test enable done");
    for (int i = 0; i < 29; i++) begin
      lat = 4'(i % 4);
      i2c = (i == 24 || i == 25);
      wrFlag(1, 0);
      fire(i);
      take(6'(i < 24 ? i + 5 : (i < 26 ? i - 9 : i + 3)));
    end
    i2c = 0;
    $display("test map done");
    cause = 2'b11;
    wrFlag(1, 0);
    fire(3);
    none("shared eight");
    fire(4);
    none("shared nine");
    cause = 2'b00;
    i2c = 1;
    fire(10);
    none("i2c plain transmit");
    i2c = 0;
    wrFlag(1, 3);
    fire(16);
    none("level at threshold");
    wrFlag(1, 2);
    take(21);
    wrCtrl(22, 0, 0);
    wrFlag(1, 0);
    fire(17);
    none("level zero");
    wrCtrl(22, 0, 0);
    check("software clear", 0, ctrlState[22].request);
    wrCtrl(23, 1, 3);
    check("software set", 0, ctrlState[23].request);
    $display("test refusal done");
    wrFlag(0, 7);
    swCall(0);
    take(0);
    swCall(63);
    take(63);
    $display("test software done");
    complete_run();
  end
endmodule
